// file: adc_result_accumulator_filter.sv
// Post-conversion accumulator, averager and low-pass filter with its
// AXI4-Lite register file. Assumes converter results arrive on sys_clk.
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ns

// Overview of operation
// RULE_01: Sample one is the new result, or the previous one when pairing.
// RULE_02: A cycle is one conversion, or two when double sampling is on.
// RULE_03: Accumulate/average add sample term, counter saturates at FF.
// RULE_04: Average clears on software clear or on a trigger when full.
// RULE_05: Burst clears on software clear, on start or on a retrigger.
// RULE_06: Burst repeats conversions until counter reaches repeat count.
// RULE_07: At threshold event flags, filtered value and count are valid.
// RULE_08: Filter mode adds term plus acc minus acc shifted each cycle.
// RULE_09: Basic mode leaves acc and counter alone, tests every sample.
// RULE_10: Overflow flag sets when a sum exceeds the 16-bit range.
// RULE_11: Software clear wipes acc, overflow and counter, then self-clears.
// RULE_12: A met threshold condition after a computation sets the flag.
module adc_result_accumulator_filter (
  input  wire logic                  sys_clk,       // 50 MHz clock
  input  wire logic                  sys_rst,       // Sync reset, high
  input  wire acc_filter_pkg::conv_t conv_in,       // Finished conversion
  input  wire logic                  retrigger_in,  // External trigger
  output logic                       conv_trigger,  // Start a conversion
  output logic                       threshold_irq, // Threshold flag level
  input  wire logic [7:0]            s_axi_awaddr,  // Write address
  input  wire logic                  s_axi_awvalid, // Write addr valid
  output logic                       s_axi_awready, // Write addr ready
  input  wire logic [31:0]           s_axi_wdata,   // Write data
  input  wire logic [3:0]            s_axi_wstrb,   // Byte enables
  input  wire logic                  s_axi_wvalid,  // Write data valid
  output logic                       s_axi_wready,  // Write data ready
  output logic [1:0]                 s_axi_bresp,   // Write response
  output logic                       s_axi_bvalid,  // Response valid
  input  wire logic                  s_axi_bready,  // Response ready
  input  wire logic [7:0]            s_axi_araddr,  // Read address
  input  wire logic                  s_axi_arvalid, // Read addr valid
  output logic                       s_axi_arready, // Read addr ready
  output logic [31:0]                s_axi_rdata,   // Read data
  output logic [1:0]                 s_axi_rresp,   // Read response
  output logic                       s_axi_rvalid,  // Read data valid
  input  wire logic                  s_axi_rready   // Read data ready
);

  // Bus slave state
  logic                       aw_hold_q;
  logic [7:0]                 aw_addr_q;
  logic                       w_hold_q;
  logic [31:0]                w_data_q;
  logic [3:0]                 w_strb_q;
  logic                       bvalid_q;
  logic [1:0]                 bresp_q;
  logic                       rvalid_q;
  logic [31:0]                rdata_q;
  logic [1:0]                 rresp_q;
  logic                       wr_fire;
  logic                       wr_known;

  // Configuration and computation state
  acc_filter_pkg::mode_t      mode_q;
  acc_filter_pkg::th_mode_t   tmode_q;
  logic                       dse_q;
  logic [2:0]                 shift_q;
  logic [7:0]                 rpt_q;
  logic [15:0]                thresh_q;
  logic                       go_q;
  logic                       aclr_q;
  logic [15:0]                acc_q;
  logic [7:0]                 cnt_q;
  logic [15:0]                filt_q;
  logic [15:0]                prev_q;
  logic                       phase_q;
  logic                       aov_q;
  logic                       tif_q;
  logic                       trig_q;

  // Combinational terms
  logic                       wr_ctrl;
  logic                       start_ev;
  logic                       trig_ev;
  logic                       clr_ev;
  logic                       cycle_done;
  logic                       accumulating;
  logic [15:0]                acc_base;
  logic [7:0]                 cnt_base;
  logic [7:0]                 cnt_next;
  logic [16:0]                term;
  logic [16:0]                sum;
  logic [15:0]                filt_next;
  logic [15:0]                err;
  logic                       test_en;
  logic                       th_hit;
  logic                       ovf_ev;
  logic                       tif_set;
  logic                       burst_again;

  // Handshakes: each channel is held off while a response is pending
  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign wr_fire       = aw_hold_q & w_hold_q;
  assign wr_known      = aw_addr_q == acc_filter_pkg::OFF_CTRL
                      || aw_addr_q == acc_filter_pkg::OFF_REPEAT
                      || aw_addr_q == acc_filter_pkg::OFF_THRESH
                      || aw_addr_q == acc_filter_pkg::OFF_STATUS;

  // Address and data may arrive in either order
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_hold_q  <= 1'b0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      else if (wr_fire)
        aw_hold_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_hold_q <= 1'b0;
    end
  end

  // Write response one cycle after both halves are held
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= acc_filter_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_known ? acc_filter_pkg::RESP_OKAY
                           : acc_filter_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  // Read path, answered the cycle after the address is taken
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= acc_filter_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= acc_filter_pkg::RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
      if (s_axi_araddr[7:2] == acc_filter_pkg::OFF_CTRL[7:2])
        rdata_q <= {21'h0, tmode_q, aclr_q, go_q, shift_q, dse_q, mode_q};
      else if (s_axi_araddr[7:2] == acc_filter_pkg::OFF_REPEAT[7:2])
        rdata_q <= {24'h0, rpt_q};
      else if (s_axi_araddr[7:2] == acc_filter_pkg::OFF_THRESH[7:2])
        rdata_q <= {16'h0, thresh_q};
      else if (s_axi_araddr[7:2] == acc_filter_pkg::OFF_STATUS[7:2])
        rdata_q <= {16'h0, cnt_q, 6'h0, tif_q, aov_q};
      else if (s_axi_araddr[7:2] == acc_filter_pkg::OFF_ACCUM[7:2])
        rdata_q <= {16'h0, acc_q};
      else if (s_axi_araddr[7:2] == acc_filter_pkg::OFF_FILTER[7:2])
        rdata_q <= {16'h0, filt_q};
      else if (s_axi_araddr[7:2] == acc_filter_pkg::OFF_PREV[7:2])
        rdata_q <= {16'h0, prev_q};
      else
        rresp_q <= acc_filter_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // Trigger and clear events
  assign wr_ctrl  = wr_fire && aw_addr_q == acc_filter_pkg::OFF_CTRL;
  assign start_ev = wr_ctrl && w_strb_q[0] && ~go_q
                 && w_data_q[acc_filter_pkg::CTRL_GO_BIT];
  assign trig_ev  = start_ev | retrigger_in;
  assign clr_ev   = aclr_q                                         // RULE_11
                 | (mode_q == acc_filter_pkg::MODE_AVERAGE && trig_ev
                    && cnt_q >= rpt_q)                              // RULE_04
                 | (mode_q == acc_filter_pkg::MODE_BURST && trig_ev); // RULE_05

  // Sample terms; a clear in the same cycle still keeps the new sample
  assign cycle_done   = conv_in.valid & (~dse_q | phase_q);         // RULE_02
  assign accumulating = mode_q == acc_filter_pkg::MODE_ACCUM
                     || mode_q == acc_filter_pkg::MODE_AVERAGE
                     || mode_q == acc_filter_pkg::MODE_BURST
                     || mode_q == acc_filter_pkg::MODE_LPF;
  assign acc_base  = clr_ev ? 16'h0000 : acc_q;
  assign cnt_base  = clr_ev ? 8'h00 : cnt_q;
  assign cnt_next  = (cnt_base == acc_filter_pkg::CNT_MAX) ? cnt_base
                   : cnt_base + 8'h01;                              // RULE_03
  assign term      = dse_q ? {1'b0, conv_in.result} - {1'b0, prev_q}
                           : {1'b0, conv_in.result};                // RULE_01

  // Sum wraps negative differences into bit 16 as well
  always_comb
  begin
    if (mode_q == acc_filter_pkg::MODE_LPF)
      sum = term + {1'b0, acc_base}
          - {1'b0, acc_base >> shift_q};                            // RULE_08
    else
      sum = term + {1'b0, acc_base};                                // RULE_03
    if (mode_q == acc_filter_pkg::MODE_LPF)
      filt_next = sum[15:0];                                        // RULE_07
    else
      filt_next = sum[15:0] >> shift_q;                             // RULE_07
  end

  // Threshold test on the filtered value, or the raw term in basic mode
  assign ovf_ev  = cycle_done & accumulating & sum[16];             // RULE_10
  assign test_en = mode_q == acc_filter_pkg::MODE_ACCUM || !accumulating
                || cnt_next >= rpt_q;                               // RULE_04
  assign err     = accumulating ? filt_next : term[15:0];           // RULE_09

  always_comb
  begin
    case (tmode_q)
      acc_filter_pkg::TH_ALWAYS: th_hit = 1'b1;
      acc_filter_pkg::TH_ABOVE:  th_hit = $signed(err) > $signed(thresh_q);
      acc_filter_pkg::TH_BELOW:  th_hit = $signed(err) < $signed(thresh_q);
      default:                   th_hit = 1'b0;
    endcase
  end

  // Overflow signals in accumulate mode or once the count reaches the repeat count, so handlers should check the overflow flag
  assign tif_set     = cycle_done & test_en & (th_hit | ovf_ev);    // RULE_12
  assign burst_again = cycle_done && go_q
                    && mode_q == acc_filter_pkg::MODE_BURST
                    && cnt_next < rpt_q;                            // RULE_06

  // Configuration written by software
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      mode_q   <= acc_filter_pkg::MODE_BASIC;
      dse_q    <= 1'b0;
      shift_q  <= 3'h0;
      tmode_q  <= acc_filter_pkg::TH_NEVER;
      rpt_q    <= acc_filter_pkg::RST_REPEAT;
      thresh_q <= acc_filter_pkg::RST_THRESH;
    end
    else if (wr_fire)
    begin
      if (wr_ctrl && w_strb_q[0])
      begin
        mode_q  <= acc_filter_pkg::mode_t'(w_data_q[2:0]);
        dse_q   <= w_data_q[acc_filter_pkg::CTRL_DSE_BIT];
        shift_q <= w_data_q[6:4];
      end
      if (wr_ctrl && w_strb_q[1])
        tmode_q <= acc_filter_pkg::th_mode_t'(w_data_q[10:9]);
      if (aw_addr_q == acc_filter_pkg::OFF_REPEAT && w_strb_q[0])
        rpt_q <= w_data_q[7:0];
      if (aw_addr_q == acc_filter_pkg::OFF_THRESH && w_strb_q[0])
        thresh_q[7:0] <= w_data_q[7:0];
      if (aw_addr_q == acc_filter_pkg::OFF_THRESH && w_strb_q[1])
        thresh_q[15:8] <= w_data_q[15:8];
    end
  end

  // Software clear lasts one cycle, then drops by itself
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      aclr_q <= 1'b0;
    else if (wr_ctrl && w_strb_q[1] && w_data_q[acc_filter_pkg::CTRL_ACLR_BIT])
      aclr_q <= 1'b1;
    else
      aclr_q <= 1'b0;                                               // RULE_11
  end

  // Run flag and conversion requests; bursts keep requesting
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      go_q   <= 1'b0;
      trig_q <= 1'b0;
    end
    else
    begin
      trig_q <= trig_ev | burst_again;                              // RULE_06
      if (start_ev)
        go_q <= 1'b1;
      else if (cycle_done && !burst_again)
        go_q <= 1'b0;
    end
  end

  // Pairing of conversions and the held previous result
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      prev_q  <= 16'h0000;
      phase_q <= 1'b0;
    end
    else if (conv_in.valid)
    begin
      prev_q  <= conv_in.result;                                    // RULE_01
      phase_q <= dse_q & ~phase_q;                                  // RULE_02
    end
    else if (!dse_q)
      phase_q <= 1'b0;
  end

  // Accumulator, counter and filtered result
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      acc_q  <= 16'h0000;
      cnt_q  <= 8'h00;
      filt_q <= 16'h0000;
    end
    else if (cycle_done && accumulating)
    begin
      acc_q  <= sum[15:0];                                          // RULE_03
      cnt_q  <= cnt_next;                                           // RULE_03
      filt_q <= filt_next;                                          // RULE_07
    end
    else
    begin
      acc_q <= acc_base;                                            // RULE_09
      cnt_q <= cnt_base;                                            // RULE_09
    end
  end

  // Sticky flags; a new event beats a clear in the same cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      aov_q <= 1'b0;
      tif_q <= 1'b0;
    end
    else
    begin
      if (ovf_ev)
        aov_q <= 1'b1;                                              // RULE_10
      else if (aclr_q)
        aov_q <= 1'b0;                                              // RULE_11
      if (tif_set)
        tif_q <= 1'b1;                                              // RULE_12
      else if (wr_fire && aw_addr_q == acc_filter_pkg::OFF_STATUS
               && w_strb_q[0] && w_data_q[acc_filter_pkg::STAT_TIF_BIT])
        tif_q <= 1'b0;
    end
  end

  assign conv_trigger  = trig_q;
  assign threshold_irq = tif_q;

endmodule

// file: acc_filter_pkg.sv
// Constants and types shared by the result accumulator/filter block.
// Assumes a single 50 MHz clock domain and a 32-bit AXI4-Lite register bus.
package acc_filter_pkg;

  // Byte addresses of the registers
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_REPEAT     = 8'h04;
  localparam logic [7:0]  OFF_THRESH     = 8'h08;
  localparam logic [7:0]  OFF_STATUS     = 8'h0C;
  localparam logic [7:0]  OFF_ACCUM      = 8'h10;
  localparam logic [7:0]  OFF_FILTER     = 8'h14;
  localparam logic [7:0]  OFF_PREV       = 8'h18;

  // Control register fields
  localparam int unsigned CTRL_MODE_LSB  = 0;
  localparam int unsigned CTRL_DSE_BIT   = 3;
  localparam int unsigned CTRL_SHIFT_LSB = 4;
  localparam int unsigned CTRL_GO_BIT    = 7;
  localparam int unsigned CTRL_ACLR_BIT  = 8;
  localparam int unsigned CTRL_TMODE_LSB = 9;

  // Status register fields
  localparam int unsigned STAT_AOV_BIT   = 0;
  localparam int unsigned STAT_TIF_BIT   = 1;
  localparam int unsigned STAT_CNT_LSB   = 8;

  // Values after reset and limits
  localparam logic [7:0]  RST_REPEAT     = 8'h01;
  localparam logic [15:0] RST_THRESH     = 16'h0000;
  localparam logic [7:0]  CNT_MAX        = 8'hFF;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // Computation modes, encoded 0..4 in mode_select
  typedef enum logic [2:0] {
    MODE_BASIC,
    MODE_ACCUM,
    MODE_AVERAGE,
    MODE_BURST,
    MODE_LPF
  } mode_t;

  // Threshold test selection
  typedef enum logic [1:0] {
    TH_NEVER,
    TH_ALWAYS,
    TH_ABOVE,
    TH_BELOW
  } th_mode_t;

  // One finished conversion from the converter
  typedef struct packed {
    logic        valid;
    logic [15:0] result;
  } conv_t;

endpackage

// file: acc_filter_asserts.sv
// Port checker for the result accumulator: bus answers and flag timing.
// Bound to the design top; one clock, synchronous active-high reset.
`timescale 1ns/1ns
module acc_filter_asserts (
  input wire logic                  sys_clk,       // Clock
  input wire logic                  sys_rst,       // Reset
  input wire acc_filter_pkg::conv_t conv_in,       // Conversion
  input wire logic                  conv_trigger,  // Request
  input wire logic                  threshold_irq, // Flag
  input wire logic                  s_axi_awready, // AW ready
  input wire logic                  s_axi_wready,  // W ready
  input wire logic                  s_axi_bvalid,  // B valid
  input wire logic                  s_axi_bready,  // B ready
  input wire logic [1:0]            s_axi_bresp,   // B response
  input wire logic                  s_axi_arvalid, // AR valid
  input wire logic                  s_axi_arready, // AR ready
  input wire logic [31:0]           s_axi_rdata,   // R data
  input wire logic                  s_axi_rvalid,  // R valid
  input wire logic                  s_axi_rready   // R ready
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // Read request taken, answer one cycle later
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  AST_AR_READY: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not inverse of rvalid");
  // Answers stand until taken
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_B_REFUSE: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  // Flag rises only from a computation, falls only at a write
  AST_IRQ_RISE: assert property ($rose(threshold_irq)
    |-> $past(conv_in.valid))
    else $error("flag rose without a conversion");
  AST_IRQ_FALL: assert property ($fell(threshold_irq)
    |-> $rose(s_axi_bvalid))
    else $error("flag fell without a write");
  // Requests come from a start write, a finished burst step or retrigger_in; only the first two are checked
  AST_TRIG_CAUSE: assert property (conv_trigger
    |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(conv_in.valid)
        || $past(conv_in.valid, 2))
    else $error("conversion request without cause");
endmodule

bind adc_result_accumulator_filter acc_filter_asserts u_asserts (
  .sys_clk, .sys_rst, .conv_in, .conv_trigger, .threshold_irq,
  .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready
);

// file: conv_model.sv
// Converter result model: answers a request after delay_in cycles.
// Assumes delay_in is at least one and requests do not overlap.
`timescale 1ns/1ns
module conv_model (
  input  wire logic           sys_clk,   // Clock
  input  wire logic           sys_rst,   // Reset
  input  wire logic           start_in,  // Request
  input  wire logic [3:0]     delay_in,  // Answer delay
  input  wire logic [15:0]    sample_in, // Next result
  output acc_filter_pkg::conv_t conv_out // Finished conversion
);
  logic [3:0]  wait_q; // Cycles left
  logic [15:0] last_q; // Last result sent
  // Bus shows the inverse of the last result between pulses
  always_ff @(posedge sys_clk)
  begin
    conv_out.valid <= 1'b0;
    conv_out.result <= ~last_q;
    if (sys_rst)
      wait_q <= 4'h0;
    else if (start_in)
      wait_q <= delay_in;
    else if (wait_q != 4'h0)
      wait_q <= wait_q - 4'h1;
    if (sys_rst)
      last_q <= 16'h0000;
    else if (!start_in && wait_q == 4'h1)
    begin
      conv_out.valid <= 1'b1;
      conv_out.result <= sample_in;
      last_q <= sample_in;
    end
  end
endmodule

// file: adc_result_accumulator_filter_tb_top.sv
// Self-checking bench for the result accumulator over AXI4-Lite.
// Assumes conv_model answers pushes and conversion requests.
`timescale 1ns/1ns
module adc_result_accumulator_filter_tb_top;
  // Bench signals, named after the design ports
  logic                  sys_clk, sys_rst, conv_trigger, threshold_irq;
  logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic                  s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                  s_axi_rready, push_in, retrigger_in;
  logic [7:0]            s_axi_awaddr, s_axi_araddr;
  logic [31:0]           s_axi_wdata, s_axi_rdata;
  logic [3:0]            s_axi_wstrb, delay_in;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic [15:0]           sample_in;
  acc_filter_pkg::conv_t conv_in;
  int                    err_count, checked, nconv;
  // Design and its converter
  adc_result_accumulator_filter DUT (
    .sys_clk, .sys_rst, .conv_in, .retrigger_in, .conv_trigger,
    .threshold_irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  conv_model PARTNER (
    .sys_clk, .sys_rst, .start_in(conv_trigger || push_in), .delay_in,
    .sample_in, .conv_out(conv_in)
  );
  // 50 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Finished conversions, for waits and burst length
  always @(posedge sys_clk)
    if (conv_in.valid === 1'b1)
      nconv <= nconv + 1;
  task automatic results;
    $display("Errors %0d, checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Every wait is bounded; running out ends the run
  task automatic bound(input int n);
    if (n >= 400)
    begin
      err_count++;
      $display("ERROR at %0t: wait %h limit %h", $time, n, 400);
      results();
    end
  endtask
  // Write; bready comes late so the answer must stand
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n == 2) s_axi_bready <= 1'b1;
      n++;
    end
    while (!(s_axi_bvalid && s_axi_bready) && n < 400);
    bound(n);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n == 1) s_axi_rready <= 1'b1;
      n++;
    end
    while (!(s_axi_rvalid && s_axi_rready) && n < 400);
    bound(n);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_chk(a, e, acc_filter_pkg::RESP_OKAY);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    axi_wr(a, d, acc_filter_pkg::RESP_OKAY);
  endtask
  task automatic ctrl(input logic [31:0] d);
    wr(acc_filter_pkg::OFF_CTRL, d);
  endtask
  task automatic clr_tif;
    wr(acc_filter_pkg::OFF_STATUS, 32'h0000_0002);
  endtask
  // Offer a result, by push or by a start write, wait for k results
  task automatic fire(input logic [15:0] v, input logic [31:0] c,
                      input int k);
    int t;
    int n;
    @(posedge sys_clk);
    t = nconv + k;
    sample_in <= v;
    if (c == 32'h0)
    begin
      push_in <= 1'b1;
      @(posedge sys_clk);
      push_in <= 1'b0;
    end
    else
      ctrl(c);
    n = 0;
    while (nconv < t && n < 400)
    begin
      @(posedge sys_clk);
      n++;
    end
    bound(n);
    #1;
  endtask
  task automatic push(input logic [15:0] v);
    fire(v, 32'h0, 1);
  endtask
  // Reset values, unmapped and read-only places
  task automatic t_reset;
    rd(acc_filter_pkg::OFF_REPEAT, {24'h0, acc_filter_pkg::RST_REPEAT});
    rd(acc_filter_pkg::OFF_STATUS, 32'h0);
    rd_chk(8'h1C, 32'h0, acc_filter_pkg::RESP_SLVERR);
    axi_wr(acc_filter_pkg::OFF_ACCUM, 32'hFFFF,
           acc_filter_pkg::RESP_SLVERR);
    rd(acc_filter_pkg::OFF_ACCUM, 32'h0);
  endtask
  // Accumulate with overflow, software clear, counter saturation
  task automatic t_accum;
    ctrl(32'h0000_0311);
    push(16'hFFF0);
    push(16'h0020);
    rd(acc_filter_pkg::OFF_ACCUM, 32'h0000_0010);
    rd(acc_filter_pkg::OFF_FILTER, 32'h0000_0008);
    rd(acc_filter_pkg::OFF_STATUS, 32'h0000_0203);
    ctrl(32'h0000_0311);
    rd(acc_filter_pkg::OFF_CTRL, 32'h0000_0211);
    rd(acc_filter_pkg::OFF_STATUS, 32'h0000_0002);
    clr_tif();
    chk({31'h0, threshold_irq}, 32'h0);
    repeat (257) push(16'h0001);
    rd(acc_filter_pkg::OFF_STATUS, 32'h0000_FF02);
    rd(acc_filter_pkg::OFF_ACCUM, 32'h0000_0101);
  endtask
  // Basic mode tests each sample, sums stay put
  task automatic t_basic;
    ctrl(32'h0000_0200);
    clr_tif();
    push(16'h0007);
    chk({31'h0, threshold_irq}, 32'h1);
    rd(acc_filter_pkg::OFF_ACCUM, 32'h0000_0101);
    rd(acc_filter_pkg::OFF_STATUS, 32'h0000_FF02);
  endtask
  // Average: test only when full, start when full clears first
  task automatic t_average;
    ctrl(32'h0000_0312);
    wr(acc_filter_pkg::OFF_REPEAT, 32'h0000_0002);
    clr_tif();
    push(16'h0004);
    chk({31'h0, threshold_irq}, 32'h0);
    push(16'h0006);
    chk({31'h0, threshold_irq}, 32'h1);
    rd(acc_filter_pkg::OFF_FILTER, 32'h0000_0005);
    fire(16'h0008, 32'h0000_0292, 1);
    rd(acc_filter_pkg::OFF_ACCUM, 32'h0000_0008);
    rd(acc_filter_pkg::OFF_STATUS, 32'h0000_0102);
  endtask
  // Burst of three with a slow converter
  task automatic t_burst;
    int n0;
    delay_in <= 4'h5;
    wr(acc_filter_pkg::OFF_REPEAT, 32'h0000_0003);
    ctrl(32'h0000_0203);
    clr_tif();
    n0 = nconv;
    fire(16'h0003, 32'h0000_0283, 3);
    repeat (40) @(posedge sys_clk);
    chk(32'(nconv - n0), 32'h0000_0003);
    chk({31'h0, threshold_irq}, 32'h1);
    rd(acc_filter_pkg::OFF_ACCUM, 32'h0000_0009);
    rd(acc_filter_pkg::OFF_STATUS, 32'h0000_0302);
    rd(acc_filter_pkg::OFF_FILTER, 32'h0000_0009);
    delay_in <= 4'h1;
  endtask
  // Low-pass step response with shift one
  task automatic t_lpf;
    ctrl(32'h0000_0314);
    wr(acc_filter_pkg::OFF_REPEAT, 32'h0000_0002);
    clr_tif();
    push(16'h0008);
    chk({31'h0, threshold_irq}, 32'h0);
    rd(acc_filter_pkg::OFF_ACCUM, 32'h0000_0008);
    push(16'h0008);
    rd(acc_filter_pkg::OFF_ACCUM, 32'h0000_000C);
    rd(acc_filter_pkg::OFF_FILTER, 32'h0000_000C);
    chk({31'h0, threshold_irq}, 32'h1);
  endtask
  // Double sampling: a pair makes one cycle of difference
  task automatic t_double;
    ctrl(32'h0000_0309);
    clr_tif();
    push(16'h0005);
    rd(acc_filter_pkg::OFF_STATUS, 32'h0);
    rd(acc_filter_pkg::OFF_PREV, 32'h0000_0005);
    push(16'h0009);
    rd(acc_filter_pkg::OFF_ACCUM, 32'h0000_0004);
    rd(acc_filter_pkg::OFF_STATUS, 32'h0000_0102);
  endtask
  // Reset, then the scenarios in turn
  initial
  begin
    sys_rst = 1'b1;
    {push_in, retrigger_in, s_axi_awvalid, s_axi_wvalid} = 4'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, sample_in} = 64'h0;
    s_axi_wstrb = 4'hF;
    delay_in = 4'h1;
    {err_count, checked, nconv} = 96'h0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_accum();
    t_basic();
    t_average();
    t_burst();
    t_lpf();
    t_double();
    results();
  end
endmodule
